// ==== hdl/tone_rx_consts.svh ====
// Constants for the tone generator two and receive frequency meter block
`ifndef TONE_RX_CONSTS_SVH
`define TONE_RX_CONSTS_SVH
// ----------------------------------------
// Address/command bytes
// ----------------------------------------
`define CMD_RX_RESULT 8'h32
`define CMD_TONE_TWO 8'h35
`define CMD_STATUS_READ 8'h3f
`define CMD_GENERAL_RESET 8'h01
// ----------------------------------------
// Tone two command word fields
// ----------------------------------------
`define TONE_FREQ_MSB 12
`define TONE_BIAS_BIT 13
`define TONE_WAVE_BIT 14
`define TONE_WORD_RESET 16'h0000
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STATUS_RX_DONE_BIT 0
// ----------------------------------------
// Measurement timing, crystal based
// ----------------------------------------
`define XTAL_HZ 4032000
`define MEAS_CLK_HIGH_HZ 56000
`define MEAS_CLK_MID_HZ 28000
`define WINDOW_HIGH_US 9125
`define WINDOW_MID_US 18250
`define DIV_HIGH (`XTAL_HZ / `MEAS_CLK_HIGH_HZ)
`define DIV_MID (`XTAL_HZ / `MEAS_CLK_MID_HZ)
`define WINDOW_TICKS (`WINDOW_HIGH_US * `MEAS_CLK_HIGH_HZ / 1000000)
`endif

// ==== hdl/tone_rx_pkg.sv ====
// Types for the tone generator two and receive frequency meter block
`default_nettype none
package tone_rx_pkg;
   typedef enum logic [1:0] {
      METER_ARM = 2'b01,
      METER_RUN = 2'b10
   } meter_state_type;
   typedef enum logic [2:0] {
      BUS_ADDR = 3'b001,
      BUS_DATA_IN = 3'b010,
      BUS_DATA_OUT = 3'b100
   } bus_state_type;
   typedef enum logic [1:0] {
      CUE_LOW_SUPPLY = 2'b00,
      CUE_MID_SUPPLY = 2'b01,
      CUE_SQUARE = 2'b10,
      CUE_SINE = 2'b11
   } cue_mode_type;
endpackage
`default_nettype wire

// ==== hdl/tone_gen2_and_rx_freq_meter.sv ====
// Tone generator two command word and receive frequency meter, serial control slave
`timescale 1ns/10ps
`default_nettype none
`include "tone_rx_consts.svh"

module tone_gen2_and_rx_freq_meter #(
   parameter int WINDOW_TICKS = `WINDOW_TICKS
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic serial_clock_in,
   input wire logic command_data_in,
   input wire logic chip_select_n_in,
   input wire logic xtal_clock_in,
   input wire logic filtered_input_in,
   input wire logic signal_valid_in,
   input wire logic mid_band_in,
   input wire logic gen1_powersave_in,
   input wire logic irq_enable_in,
   output logic reply_data_out,
   output logic [12:0] freq_word_out,
   output tone_rx_pkg::cue_mode_type calibration_cue_output_out,
   output logic gen2_powersave_out,
   output logic sum_amp_powersave_out,
   output logic rx_complete_out,
   output logic irq_n_out
);

   // ----------------------------------------
   // Edge detection of sampled inputs
   // ----------------------------------------
   logic xtal_prev_reg;
   logic input_prev_reg;
   logic sclk_prev_reg;
   logic xtal_edge;
   logic input_edge;
   logic sclk_rise;
   logic sclk_fall;

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         xtal_prev_reg <= 1'b0;
         input_prev_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end else begin
         xtal_prev_reg <= xtal_clock_in;
         input_prev_reg <= filtered_input_in;
         sclk_prev_reg <= serial_clock_in;
      end
   end

   assign xtal_edge = xtal_clock_in & ~xtal_prev_reg;
   // Both edges counted: each is half a cycle, so counting doubles the frequency
   assign input_edge = filtered_input_in ^ input_prev_reg;
   assign sclk_rise = serial_clock_in & ~sclk_prev_reg & ~chip_select_n_in;
   assign sclk_fall = ~serial_clock_in & sclk_prev_reg & ~chip_select_n_in;

   // ----------------------------------------
   // Measurement window and counting
   // ----------------------------------------
   tone_rx_pkg::meter_state_type meter_state_reg, meter_state_next;
   logic [7:0] div_cnt_reg, div_cnt_next;
   logic [8:0] win_cnt_reg, win_cnt_next;
   logic [8:0] edge_cnt_reg, edge_cnt_next;
   logic [8:0] last_edge_reg, last_edge_next;
   logic band_mid_reg, band_mid_next;
   logic [7:0] result_n_reg, result_n_next;
   logic [7:0] result_r_reg, result_r_next;
   logic done_pulse;
   logic [7:0] div_top;
   logic meas_tick;

   function automatic logic [7:0] sat8(input logic [8:0] v);
      sat8 = v[8] ? 8'hff : v[7:0];
   endfunction

   // Measuring clock from the crystal: ratios keep window and clock scaling together
   assign div_top = band_mid_reg ? 8'(`DIV_MID - 1) : 8'(`DIV_HIGH - 1);
   assign meas_tick = xtal_edge && (div_cnt_reg == div_top);

   always_comb begin
      meter_state_next = meter_state_reg;
      div_cnt_next = div_cnt_reg;
      win_cnt_next = win_cnt_reg;
      edge_cnt_next = edge_cnt_reg;
      last_edge_next = last_edge_reg;
      band_mid_next = band_mid_reg;
      result_n_next = result_n_reg;
      result_r_next = result_r_reg;
      done_pulse = 1'b0;
      case (meter_state_reg)
         tone_rx_pkg::METER_ARM: begin
            // Window opens on an input edge so counted cycles are complete
            if (signal_valid_in && input_edge) begin
               meter_state_next = tone_rx_pkg::METER_RUN;
               div_cnt_next = 8'h00;
               win_cnt_next = 9'h000;
               edge_cnt_next = 9'h000;
               last_edge_next = 9'h000;
               band_mid_next = mid_band_in;
            end
         end
         tone_rx_pkg::METER_RUN: begin
            if (xtal_edge) begin
               div_cnt_next = meas_tick ? 8'h00 : div_cnt_reg + 8'h01;
            end
            if (meas_tick) begin
               win_cnt_next = win_cnt_reg + 9'h001;
            end
            if (input_edge) begin
               edge_cnt_next = edge_cnt_reg[8] ? edge_cnt_reg : edge_cnt_reg + 9'h001;
               last_edge_next = win_cnt_next + {8'h00, div_cnt_next > (div_top >> 1) + 8'h01};
            end
            if (!signal_valid_in || mid_band_in != band_mid_reg) begin
               // Bad signal or band change aborts; last result is kept
               meter_state_next = tone_rx_pkg::METER_ARM;
            end else if (meas_tick && win_cnt_next == 9'(WINDOW_TICKS)) begin
               meter_state_next = tone_rx_pkg::METER_ARM;
               if (edge_cnt_next != 9'h000) begin
                  result_n_next = sat8(edge_cnt_next);
                  result_r_next = sat8(9'(WINDOW_TICKS) - last_edge_next);
                  done_pulse = 1'b1;
               end
            end
         end
         default: begin
            meter_state_next = tone_rx_pkg::METER_ARM;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         meter_state_reg <= tone_rx_pkg::METER_ARM;
         div_cnt_reg <= 8'h00;
         win_cnt_reg <= 9'h000;
         edge_cnt_reg <= 9'h000;
         last_edge_reg <= 9'h000;
         band_mid_reg <= 1'b0;
         result_n_reg <= 8'h00;
         result_r_reg <= 8'h00;
      end else begin
         meter_state_reg <= meter_state_next;
         div_cnt_reg <= div_cnt_next;
         win_cnt_reg <= win_cnt_next;
         edge_cnt_reg <= edge_cnt_next;
         last_edge_reg <= last_edge_next;
         band_mid_reg <= band_mid_next;
         result_n_reg <= result_n_next;
         result_r_reg <= result_r_next;
      end
   end

   // ----------------------------------------
   // Serial control slave
   // ----------------------------------------
   tone_rx_pkg::bus_state_type bus_state_reg, bus_state_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] rx_shift_reg, rx_shift_next;
   logic [7:0] high_byte_reg, high_byte_next;
   logic [15:0] tx_shift_reg, tx_shift_next;
   logic [3:0] out_last_reg, out_last_next;
   logic [15:0] tone_word_reg, tone_word_next;
   logic reply_reg, reply_next;
   logic status_done_reg, status_done_next;
   logic [7:0] byte_in;
   logic status_clear;

   assign byte_in = {rx_shift_reg[6:0], command_data_in};

   always_comb begin
      bus_state_next = bus_state_reg;
      bit_cnt_next = bit_cnt_reg;
      rx_shift_next = rx_shift_reg;
      high_byte_next = high_byte_reg;
      tx_shift_next = tx_shift_reg;
      out_last_next = out_last_reg;
      tone_word_next = tone_word_reg;
      reply_next = reply_reg;
      status_clear = 1'b0;
      if (chip_select_n_in) begin
         // Deselect drops any half-finished transaction
         bus_state_next = tone_rx_pkg::BUS_ADDR;
         bit_cnt_next = 4'h0;
      end else if (sclk_rise) begin
         rx_shift_next = byte_in;
         bit_cnt_next = bit_cnt_reg + 4'h1;
         case (bus_state_reg)
            tone_rx_pkg::BUS_ADDR: begin
               if (bit_cnt_reg[2:0] == 3'h7) begin
                  bit_cnt_next = 4'h0;
                  case (byte_in)
                     `CMD_TONE_TWO: begin
                        bus_state_next = tone_rx_pkg::BUS_DATA_IN;
                     end
                     `CMD_RX_RESULT: begin
                        // Both bytes from one latched pair, never mixed
                        tx_shift_next = {result_n_reg, result_r_reg};
                        out_last_next = 4'hf;
                        bus_state_next = tone_rx_pkg::BUS_DATA_OUT;
                     end
                     `CMD_STATUS_READ: begin
                        tx_shift_next = {7'h00, status_done_reg, 8'h00};
                        out_last_next = 4'h7;
                        status_clear = 1'b1;
                        bus_state_next = tone_rx_pkg::BUS_DATA_OUT;
                     end
                     `CMD_GENERAL_RESET: begin
                        tone_word_next = `TONE_WORD_RESET;
                        status_clear = 1'b1;
                     end
                     default: begin
                        bus_state_next = tone_rx_pkg::BUS_ADDR;
                     end
                  endcase
               end
            end
            tone_rx_pkg::BUS_DATA_IN: begin
               if (bit_cnt_reg == 4'h7) begin
                  high_byte_next = byte_in;
               end else if (bit_cnt_reg == 4'hf) begin
                  // Bit 15 is taken as sent; a one there has no defined effect
                  tone_word_next = {high_byte_reg, byte_in};
                  bit_cnt_next = 4'h0;
                  bus_state_next = tone_rx_pkg::BUS_ADDR;
               end
            end
            tone_rx_pkg::BUS_DATA_OUT: begin
               if (bit_cnt_reg == out_last_reg) begin
                  bit_cnt_next = 4'h0;
                  bus_state_next = tone_rx_pkg::BUS_ADDR;
               end
            end
            default: begin
               bus_state_next = tone_rx_pkg::BUS_ADDR;
            end
         endcase
      end else if (sclk_fall && bus_state_reg == tone_rx_pkg::BUS_DATA_OUT) begin
         // Reply changes on the falling edge, MSB first; host samples on rising
         reply_next = tx_shift_reg[15];
         tx_shift_next = {tx_shift_reg[14:0], 1'b0};
      end
      if (bus_state_next != tone_rx_pkg::BUS_DATA_OUT) begin
         reply_next = 1'b0;
      end
      // A completion in the clearing cycle wins
      status_done_next = done_pulse | (status_done_reg & ~status_clear);
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         bus_state_reg <= tone_rx_pkg::BUS_ADDR;
         bit_cnt_reg <= 4'h0;
         rx_shift_reg <= 8'h00;
         high_byte_reg <= 8'h00;
         tx_shift_reg <= 16'h0000;
         out_last_reg <= 4'h0;
         tone_word_reg <= `TONE_WORD_RESET;
         reply_reg <= 1'b0;
         status_done_reg <= 1'b0;
      end else begin
         bus_state_reg <= bus_state_next;
         bit_cnt_reg <= bit_cnt_next;
         rx_shift_reg <= rx_shift_next;
         high_byte_reg <= high_byte_next;
         tx_shift_reg <= tx_shift_next;
         out_last_reg <= out_last_next;
         tone_word_reg <= tone_word_next;
         reply_reg <= reply_next;
         status_done_reg <= status_done_next;
      end
   end

   // ----------------------------------------
   // Generator two output control
   // ----------------------------------------
   logic gen2_ps;
   tone_rx_pkg::cue_mode_type cue_mode;

   assign gen2_ps = (tone_word_reg[`TONE_FREQ_MSB:0] == 13'h0000);

   always_comb begin
      if (gen2_ps) begin
         cue_mode = tone_rx_pkg::CUE_LOW_SUPPLY;
      end else if (tone_word_reg[`TONE_BIAS_BIT]) begin
         cue_mode = tone_rx_pkg::CUE_MID_SUPPLY;
      end else if (tone_word_reg[`TONE_WAVE_BIT]) begin
         cue_mode = tone_rx_pkg::CUE_SQUARE;
      end else begin
         cue_mode = tone_rx_pkg::CUE_SINE;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         reply_data_out <= 1'b0;
         freq_word_out <= 13'h0000;
         calibration_cue_output_out <= tone_rx_pkg::CUE_LOW_SUPPLY;
         gen2_powersave_out <= 1'b1;
         sum_amp_powersave_out <= 1'b0;
         rx_complete_out <= 1'b0;
         irq_n_out <= 1'b1;
      end else begin
         reply_data_out <= reply_reg;
         freq_word_out <= tone_word_reg[`TONE_FREQ_MSB:0];
         calibration_cue_output_out <= cue_mode;
         gen2_powersave_out <= gen2_ps;
         sum_amp_powersave_out <= gen2_ps & gen1_powersave_in;
         rx_complete_out <= status_done_reg;
         irq_n_out <= ~(status_done_reg & irq_enable_in);
      end
   end

endmodule

`default_nettype wire

// ==== testbench/tone_gen2_and_rx_freq_meter_asserts.sv ====
// Port checker for the tone generator two and receive frequency meter block
`timescale 1ns/10ps
`default_nettype none
module tone_rx_checker #(
   parameter int WINDOW_TICKS = 511
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic serial_clock_in,
   input wire logic chip_select_n_in,
   input wire logic signal_valid_in,
   input wire logic gen1_powersave_in,
   input wire logic irq_enable_in,
   input wire logic reply_data_out,
   input wire logic [12:0] freq_word_out,
   input wire tone_rx_pkg::cue_mode_type calibration_cue_output_out,
   input wire logic gen2_powersave_out,
   input wire logic sum_amp_powersave_out,
   input wire logic rx_complete_out,
   input wire logic irq_n_out
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   ps_word_a: assert property (gen2_powersave_out == (freq_word_out == 13'h0000))
      else $error("powersave does not match zero frequency word");
   cue_low_a: assert property (gen2_powersave_out |-> calibration_cue_output_out == tone_rx_pkg::CUE_LOW_SUPPLY)
      else $error("cue output not at low supply in powersave");
   cue_active_a: assert property (!gen2_powersave_out |-> calibration_cue_output_out != tone_rx_pkg::CUE_LOW_SUPPLY)
      else $error("cue output at low supply while generator runs");
   sum_amp_a: assert property (sum_amp_powersave_out == (gen2_powersave_out && $past(gen1_powersave_in)))
      else $error("summing amplifier powersave wrong");
   irq_level_a: assert property (irq_n_out == !(rx_complete_out && $past(irq_enable_in)))
      else $error("interrupt level wrong");
   rx_set_a: assert property ($rose(rx_complete_out) |-> $past(signal_valid_in, 3))
      else $error("measurement complete without valid signal");
   rx_clear_a: assert property ($fell(rx_complete_out) |-> $past(!chip_select_n_in, 2))
      else $error("status bit cleared without a command");
   freq_load_a: assert property ($changed(freq_word_out) |-> $past(!chip_select_n_in, 2))
      else $error("frequency word changed without a command");
   reply_idle_a: assert property (chip_select_n_in [*3] |-> !reply_data_out)
      else $error("reply line active while deselected");
   reply_edge_a: assert property ($rose(reply_data_out) |-> !serial_clock_in)
      else $error("reply bit changed while serial clock high");
   cover property ($rose(rx_complete_out));
   cover property ($fell(rx_complete_out));
   cover property (sum_amp_powersave_out);
endmodule
bind tone_gen2_and_rx_freq_meter tone_rx_checker #(.WINDOW_TICKS(WINDOW_TICKS)) u_chk (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .serial_clock_in(serial_clock_in),
   .chip_select_n_in(chip_select_n_in), .signal_valid_in(signal_valid_in),
   .gen1_powersave_in(gen1_powersave_in), .irq_enable_in(irq_enable_in),
   .reply_data_out(reply_data_out), .freq_word_out(freq_word_out),
   .calibration_cue_output_out(calibration_cue_output_out),
   .gen2_powersave_out(gen2_powersave_out), .sum_amp_powersave_out(sum_amp_powersave_out),
   .rx_complete_out(rx_complete_out), .irq_n_out(irq_n_out));
`default_nettype wire

// ==== testbench/host_serial_model.sv ====
// Host controller model driving the serial control bus
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
   input wire logic sys_clk_in,
   input wire logic reply_data_in,
   output logic serial_clock_out,
   output logic command_data_out,
   output logic chip_select_n_out
);
   initial begin
      serial_clock_out = 1'b0;
      command_data_out = 1'b0;
      chip_select_n_out = 1'b1;
   end
   // Six clocks a half period keeps well above the four-clock minimum
   task automatic half();
      repeat (6) @(negedge sys_clk_in);
   endtask
   // Address byte, then whole write bytes or whole reply bytes, MSB first
   task automatic xfer(input logic [7:0] addr, input int n_wr, input logic [15:0] wdata,
                       input int n_rd, output logic [15:0] rdata);
      logic [23:0] sh;
      sh = {addr, wdata};
      rdata = 16'h0000;
      @(negedge sys_clk_in);
      chip_select_n_out = 1'b0;
      half();
      for (int i = 0; i < 8 + n_wr + n_rd; i++) begin
         serial_clock_out = 1'b0;
         command_data_out = (i < 8 + n_wr) ? sh[23 - i] : ~command_data_out;
         half();
         serial_clock_out = 1'b1;
         if (i >= 8 + n_wr) begin
            rdata = {rdata[14:0], reply_data_in};
         end
         half();
      end
      serial_clock_out = 1'b0;
      half();
      chip_select_n_out = 1'b1;
      // Released data line must not keep showing a stale bit
      command_data_out = ~command_data_out;
      half();
   endtask
endmodule
`default_nettype wire

// ==== testbench/tone_gen2_and_rx_freq_meter_tb.sv ====
// Self-checking bench for the tone generator two and receive frequency meter block
`timescale 1ns/10ps
`default_nettype none
`include "tone_rx_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tone_gen2_and_rx_freq_meter_tb;
   localparam int WIN = 20;
   logic sys_clk_in = 1'b0, reset_in = 1'b1, xtal_clock_in = 1'b0, filtered_input_in = 1'b0;
   logic signal_valid_in = 1'b0, mid_band_in = 1'b0, gen1_powersave_in = 1'b0;
   logic irq_enable_in = 1'b0, reply_data_out, gen2_powersave_out, sum_amp_powersave_out;
   logic rx_complete_out, irq_n_out, run = 1'b0;
   logic [12:0] freq_word_out;
   logic [15:0] r, w, keep;
   tone_rx_pkg::cue_mode_type calibration_cue_output_out;
   wire serial_clock_in, command_data_in, chip_select_n_in;
   int n_mismatch = 0, n_tests = 0, ph = 0, tk = 0, k = 100;
   logic [15:0] words [4] = '{16'h0000, 16'h2123, 16'h4456, 16'h0789};
   always #10 sys_clk_in = ~sys_clk_in;
   host_serial_model u_host (.sys_clk_in(sys_clk_in), .reply_data_in(reply_data_out),
      .serial_clock_out(serial_clock_in), .command_data_out(command_data_in),
      .chip_select_n_out(chip_select_n_in));
   tone_gen2_and_rx_freq_meter #(.WINDOW_TICKS(WIN)) u_dut (.sys_clk_in(sys_clk_in),
      .reset_in(reset_in), .serial_clock_in(serial_clock_in), .command_data_in(command_data_in),
      .chip_select_n_in(chip_select_n_in), .xtal_clock_in(xtal_clock_in),
      .filtered_input_in(filtered_input_in), .signal_valid_in(signal_valid_in),
      .mid_band_in(mid_band_in), .gen1_powersave_in(gen1_powersave_in),
      .irq_enable_in(irq_enable_in), .reply_data_out(reply_data_out),
      .freq_word_out(freq_word_out), .calibration_cue_output_out(calibration_cue_output_out),
      .gen2_powersave_out(gen2_powersave_out), .sum_amp_powersave_out(sum_amp_powersave_out),
      .rx_complete_out(rx_complete_out), .irq_n_out(irq_n_out));
   // ----------------------------------------
   // Crystal of 12 clocks; input toggles every k crystal ticks
   // ----------------------------------------
   always @(negedge sys_clk_in) begin
      ph = (ph == 11) ? 0 : ph + 1;
      xtal_clock_in <= (ph < 6);
      if (ph == 0 && run) begin
         if (tk >= k - 1) begin
            tk = 0;
            filtered_input_in <= ~filtered_input_in;
         end else begin
            tk++;
         end
      end
   end
   function automatic tone_rx_pkg::cue_mode_type exp_cue(input logic [15:0] v);
      if (v[12:0] == 13'h0000) return tone_rx_pkg::CUE_LOW_SUPPLY;
      if (v[13]) return tone_rx_pkg::CUE_MID_SUPPLY;
      return v[14] ? tone_rx_pkg::CUE_SQUARE : tone_rx_pkg::CUE_SINE;
   endfunction
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Window is WIN measuring ticks of div crystal ticks; N and R worked out in crystal ticks
   task automatic measure(input logic mid, input int half_k);
      int div, n, rr, cnt, f, fx;
      div = mid ? 144 : 72;
      n = (div * WIN) / half_k;
      rr = (div * WIN - n * half_k + div / 2) / div;
      fx = `XTAL_HZ / 2 / half_k;
      mid_band_in = mid;
      k = half_k;
      irq_enable_in = 1'b1;
      signal_valid_in = 1'b1;
      run = 1'b1;
      cnt = 0;
      while (rx_complete_out !== 1'b1 && cnt < 45000) begin
         @(negedge sys_clk_in);
         cnt++;
      end
      run = 1'b0;
      signal_valid_in = 1'b0;
      `CHK(rx_complete_out, 1'b1)
      `CHK(irq_n_out, 1'b0)
      irq_enable_in = 1'b0;
      repeat (3) @(negedge sys_clk_in);
      `CHK(irq_n_out, 1'b1)
      u_host.xfer(`CMD_RX_RESULT, 0, 16'h0000, 16, r);
      `CHK(r, {n[7:0], rr[7:0]})
      // Host recovery with WIN standing in for the full window; short window, so 5 % slack
      f = (mid ? 14000 : 28000) * int'(r[15:8]) / (WIN - int'(r[7:0]));
      `CHK((f * 20 > fx * 19) && (f * 20 < fx * 21), 1'b1)
      u_host.xfer(`CMD_STATUS_READ, 0, 16'h0000, 8, r);
      `CHK(r[0], 1'b1)
      repeat (3) @(negedge sys_clk_in);
      `CHK(rx_complete_out, 1'b0)
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(negedge sys_clk_in);
      reset_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      gen1_powersave_in = 1'b1;
      foreach (words[i]) begin
         u_host.xfer(`CMD_TONE_TWO, 16, words[i], 0, r);
         repeat (3) @(negedge sys_clk_in);
         `CHK(freq_word_out, words[i][12:0])
         `CHK(calibration_cue_output_out, exp_cue(words[i]))
         `CHK(gen2_powersave_out, (words[i][12:0] == 13'h0000))
         `CHK(sum_amp_powersave_out, (words[i][12:0] == 13'h0000))
      end
      gen1_powersave_in = 1'b0;
      u_host.xfer(8'h77, 0, 16'h0000, 0, r);
      `CHK(freq_word_out, 13'h0789)
      u_host.xfer(`CMD_GENERAL_RESET, 0, 16'h0000, 0, r);
      repeat (3) @(negedge sys_clk_in);
      `CHK(gen2_powersave_out, 1'b1)
      `CHK(sum_amp_powersave_out, 1'b0)
      measure(1'b0, 100);
      // Leftover under half a tick must round down
      measure(1'b0, 130);
      measure(1'b1, 250);
      u_host.xfer(`CMD_RX_RESULT, 0, 16'h0000, 16, keep);
      // Aborted window must leave the stored pair alone
      signal_valid_in = 1'b1;
      run = 1'b1;
      repeat (5000) @(negedge sys_clk_in);
      signal_valid_in = 1'b0;
      run = 1'b0;
      u_host.xfer(`CMD_RX_RESULT, 0, 16'h0000, 16, r);
      `CHK(r, keep)
      `CHK(rx_complete_out, 1'b0)
      wrap_up();
   end
   initial begin
      repeat (95000) @(posedge sys_clk_in);
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
